// [design/srs_pkg.sv]
// Shared constants and types for the two-wire serial RAM slave port and its master.
package srs_pkg;

  // Memory organisation and addressing.
  localparam int unsigned     PTR_W         = 6;
  localparam logic [5:0]      LAST_LOC      = 6'h3F;
  localparam logic [5:0]      FIRST_LOC     = 6'h00;
  localparam logic [7:0]      SLAVE_ADDR    = 8'hD0;
  localparam logic [3:0]      BYTE_BITS     = 4'h8;
  localparam logic [3:0]      LAST_TX_BIT   = 4'h7;
  localparam logic [3:0]      CNT_RESET     = 4'h0;
  localparam logic [5:0]      PTR_RESET     = 6'h00;

  // Reference clock period and bus timing minimum figures, in nanoseconds.
  localparam int unsigned     CLK_PERIOD_NS = 5;
  localparam int unsigned     T_LOW_NS      = 4700;
  localparam int unsigned     T_HIGH_NS     = 4000;
  localparam int unsigned     T_SU_STA_NS   = 4700;
  localparam int unsigned     T_HD_STA_NS   = 4000;
  localparam int unsigned     T_SU_STO_NS   = 4700;
  localparam int unsigned     T_BUF_NS      = 4700;

  // Least times round up to whole clock cycles.
  localparam logic [9:0] LOW_CYC    = 10'((T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] HIGH_CYC   = 10'((T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] SU_STA_CYC = 10'((T_SU_STA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] HD_STA_CYC = 10'((T_HD_STA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] SU_STO_CYC = 10'((T_SU_STO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] BUF_CYC    = 10'((T_BUF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] TMR_ZERO   = 10'h000;

  // Byte-level commands accepted by the master.
  typedef enum logic [1:0] {
    OP_START,
    OP_STOP,
    OP_WRITE,
    OP_READ
  } srs_op_t;

endpackage

// [design/srs_bus_if.sv]
// Two-wire bus between the master and the serial RAM slave, with wired-AND resolution.
`timescale 1ns/100ps
`default_nettype none
interface srs_bus_if;
  logic scl;
  logic sda;
  logic scl_m_out;
  logic scl_m_oe;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_s_out;
  logic sda_s_oe;

  // A line is low when any enabled driver drives low, else the pull-up holds it high.
  assign scl = ~(scl_m_oe & ~scl_m_out);
  assign sda = ~((sda_m_oe & ~sda_m_out) | (sda_s_oe & ~sda_s_out));

  modport dev (
    input  scl,
    input  sda,
    output sda_s_out,
    output sda_s_oe
  );

  modport host (
    input  scl,
    input  sda,
    output scl_m_out,
    output scl_m_oe,
    output sda_m_out,
    output sda_m_oe
  );
endinterface
`default_nettype wire

// [design/srs_slave.sv]
// Serial RAM slave port: bus decoding, address pointer and 64-byte store.
//
// Behaviour
// RULE1 - each byte followed by one low acknowledge
// RULE2 - master supplies ninth acknowledge clock pulse
// RULE3 - addressed receiver acknowledges every received byte
// RULE4 - master acknowledges read bytes except last
// RULE5 - acknowledge held low through whole high phase
// RULE6 - master ends read by withholding acknowledge
// RULE7 - after unacknowledged byte release data line
// RULE8 - write: address, direction 0, word address loads pointer
// RULE9 - write bytes stored, pointer advances on acknowledge
// RULE10 - acknowledge address, word address, every data byte
// RULE11 - random read: word write, repeated start, read
// RULE12 - read sends byte at current pointer
// RULE13 - pointer advances on master acknowledge only
// RULE14 - sequential read continues until stop
// RULE15 - direct read starts at held pointer
// RULE16 - respond only to address D0h form
// RULE17 - pointer spans 64 locations in order
// RULE18 - supply failure aborts, resets pointer, ignores bus
// RULE19 - start and stop are data edges, clock high
// RULE20 - pointer wraps from 63 to 0
// RULE21 - mismatched address: no acknowledge, ignore transfer
`timescale 1ns/100ps
`default_nettype none
module srs_slave
  import srs_pkg::*;
(
  // Clock and reset.
  input  wire logic             ref_clk_in,
  input  wire logic             rst_b_in,
  // Two-wire bus.
  srs_bus_if.dev                bus,
  // Supply monitor, high while supply is above supply_switchover_threshold.
  input  wire logic             supply_ok_in,
  // Observation of the store.
  output logic [PTR_W-1:0]      ptr_out,
  output logic                  wr_strobe_out,
  output logic [7:0]            wr_data_out,
  output logic                  busy_out
);

  typedef enum logic [3:0] {
    S_IDLE,
    S_ADDR,
    S_AACK,
    S_WORD,
    S_WACK,
    S_WDATA,
    S_DACK,
    S_RDATA,
    S_RACK
  } srs_sstate_t;

  srs_sstate_t       st_q;
  logic [3:0]        cnt_q;
  logic [7:0]        sh_q;
  logic [PTR_W-1:0]  ptr_q;
  logic              oe_q;
  logic              rw_q;
  logic              mack_q;
  logic              scl_q;
  logic              sda_q;
  logic              busy_q;
  logic              wr_strobe_q;
  logic [7:0]        wr_data_q;
  logic [7:0]        mem_q [0:LAST_LOC];
  logic              scl_rise;
  logic              scl_fall;
  logic              start_c;
  logic              stop_c;
  logic              mem_we;
  logic [PTR_W-1:0]  ptr_inc;

  // Next sequential location, wrapping after the last one.
  function automatic logic [PTR_W-1:0] next_loc(input logic [PTR_W-1:0] p);
    next_loc = (p == LAST_LOC) ? FIRST_LOC : p + 6'h01; // RULE17 RULE20
  endfunction

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= bus.scl;
      sda_q <= bus.sda;
    end
  end

  assign scl_rise = bus.scl & ~scl_q;
  assign scl_fall = ~bus.scl & scl_q;
  assign start_c  = bus.scl & scl_q & sda_q & ~bus.sda; // RULE19
  assign stop_c   = bus.scl & scl_q & ~sda_q & bus.sda; // RULE19
  assign ptr_inc  = next_loc(ptr_q);
  assign mem_we   = supply_ok_in && (st_q == S_WDATA) && scl_fall && (cnt_q == BYTE_BITS);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      st_q   <= S_IDLE;
      cnt_q  <= CNT_RESET;
      sh_q   <= 8'h00;
      ptr_q  <= PTR_RESET;
      oe_q   <= 1'b0;
      rw_q   <= 1'b0;
      mack_q <= 1'b0;
    end else if (!supply_ok_in) begin
      st_q  <= S_IDLE; // RULE18
      ptr_q <= PTR_RESET; // RULE18
      oe_q  <= 1'b0; // RULE18
      cnt_q <= CNT_RESET;
    end else if (start_c) begin
      // A repeated start restarts addressing without touching the pointer.
      st_q  <= S_ADDR; // RULE11
      cnt_q <= CNT_RESET;
      oe_q  <= 1'b0;
    end else if (stop_c) begin
      st_q  <= S_IDLE; // RULE14
      cnt_q <= CNT_RESET;
      oe_q  <= 1'b0;
    end else begin
      unique case (st_q)
        S_IDLE: begin
        end
        S_ADDR, S_WORD, S_WDATA: begin
          if (scl_rise && (cnt_q < BYTE_BITS)) begin
            sh_q  <= {sh_q[6:0], bus.sda};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && (cnt_q == BYTE_BITS)) begin
            cnt_q <= CNT_RESET;
            if (st_q == S_ADDR) begin
              if (sh_q[7:1] == SLAVE_ADDR[7:1]) begin // RULE16
                oe_q <= 1'b1; // RULE10
                rw_q <= sh_q[0];
                st_q <= S_AACK;
              end else begin
                st_q <= S_IDLE; // RULE21
              end
            end else if (st_q == S_WORD) begin
              oe_q <= 1'b1; // RULE3
              st_q <= S_WACK;
            end else begin
              oe_q <= 1'b1; // RULE10
              st_q <= S_DACK;
            end
          end
        end
        S_AACK: begin
          // The acknowledge stands from the previous fall until this one.
          if (scl_fall) begin // RULE1 RULE5
            if (rw_q) begin
              sh_q <= mem_q[ptr_q]; // RULE12 RULE15
              oe_q <= ~mem_q[ptr_q][7];
              st_q <= S_RDATA;
            end else begin
              oe_q <= 1'b0;
              st_q <= S_WORD; // RULE8
            end
          end
        end
        S_WACK: begin
          if (scl_fall) begin
            ptr_q <= sh_q[PTR_W-1:0]; // RULE8
            oe_q  <= 1'b0;
            st_q  <= S_WDATA;
          end
        end
        S_DACK: begin
          if (scl_fall) begin
            ptr_q <= ptr_inc; // RULE9
            oe_q  <= 1'b0;
            st_q  <= S_WDATA;
          end
        end
        S_RDATA: begin
          if (scl_fall) begin
            if (cnt_q == LAST_TX_BIT) begin
              oe_q  <= 1'b0;
              cnt_q <= CNT_RESET;
              st_q  <= S_RACK;
            end else begin
              sh_q  <= {sh_q[6:0], 1'b0};
              oe_q  <= ~sh_q[6];
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            mack_q <= ~bus.sda;
          end else if (scl_fall) begin
            if (mack_q) begin
              ptr_q <= ptr_inc; // RULE13
              sh_q  <= mem_q[ptr_inc]; // RULE14
              oe_q  <= ~mem_q[ptr_inc][7];
              st_q  <= S_RDATA;
            end else begin
              oe_q <= 1'b0; // RULE7
              st_q <= S_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (mem_we) begin
      mem_q[ptr_q] <= sh_q; // RULE9
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      wr_strobe_q <= 1'b0;
      wr_data_q   <= 8'h00;
      busy_q      <= 1'b0;
    end else begin
      wr_strobe_q <= mem_we;
      busy_q      <= (st_q != S_IDLE);
      if (mem_we) begin
        wr_data_q <= sh_q;
      end
    end
  end

  // Open drain: the pin is only ever pulled low.
  assign bus.sda_s_out = 1'b0;
  assign bus.sda_s_oe  = oe_q;
  assign ptr_out       = ptr_q;
  assign wr_strobe_out = wr_strobe_q;
  assign wr_data_out   = wr_data_q;
  assign busy_out      = busy_q;

endmodule
`default_nettype wire

// [design/srs_master.sv]
// Byte-level two-wire bus master that drives the serial RAM slave port.
`timescale 1ns/100ps
`default_nettype none
module srs_master
  import srs_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  // Two-wire bus.
  srs_bus_if.host          bus,
  // Command port.
  input  wire logic        cmd_valid_in,
  input  wire srs_op_t     cmd_op_in,
  input  wire logic [7:0]  cmd_data_in,
  input  wire logic        cmd_ack_in,
  output logic             cmd_ready_out,
  // Result port.
  output logic             done_out,
  output logic [7:0]       rd_data_out,
  output logic             ack_seen_out
);

  typedef enum logic [3:0] {
    H_IDLE,
    H_STA_A,
    H_STA_B,
    H_STA_C,
    H_BIT_S,
    H_BIT_L,
    H_BIT_H,
    H_STO_A,
    H_STO_B,
    H_STO_C
  } srs_hstate_t;

  srs_hstate_t  st_q;
  logic [9:0]   tmr_q;
  logic [3:0]   cnt_q;
  logic [8:0]   tx_q;
  logic [7:0]   rx_q;
  logic         scl_oe_q;
  logic         sda_oe_q;
  logic         ready_q;
  logic         done_q;
  logic [7:0]   rd_q;
  logic         ack_q;
  logic         tmr_up;

  assign tmr_up = (tmr_q == TMR_ZERO);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      st_q     <= H_IDLE;
      tmr_q    <= TMR_ZERO;
      cnt_q    <= CNT_RESET;
      tx_q     <= 9'h1FF;
      rx_q     <= 8'h00;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      ready_q  <= 1'b1;
      done_q   <= 1'b0;
      rd_q     <= 8'h00;
      ack_q    <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!tmr_up) begin
        tmr_q <= tmr_q - 10'h001;
      end
      unique case (st_q)
        H_IDLE: begin
          if (cmd_valid_in) begin
            ready_q <= 1'b0;
            cnt_q   <= CNT_RESET;
            unique case (cmd_op_in)
              OP_START: begin
                st_q <= H_STA_A;
              end
              OP_STOP: begin
                st_q <= H_STO_A;
              end
              OP_WRITE: begin
                // The ninth bit is released so the slave can acknowledge.
                tx_q <= {cmd_data_in, 1'b1}; // RULE2
                st_q <= H_BIT_S;
              end
              OP_READ: begin
                tx_q <= {8'hFF, ~cmd_ack_in}; // RULE4 RULE6
                st_q <= H_BIT_S;
              end
            endcase
          end
        end
        H_STA_A: begin
          scl_oe_q <= 1'b1;
          sda_oe_q <= 1'b0;
          tmr_q    <= LOW_CYC;
          st_q     <= H_STA_B;
        end
        H_STA_B: begin
          if (tmr_up) begin
            scl_oe_q <= 1'b0;
            tmr_q    <= SU_STA_CYC;
            st_q     <= H_STA_C;
          end
        end
        H_STA_C: begin
          if (tmr_up && sda_oe_q) begin
            scl_oe_q <= 1'b1;
            ready_q  <= 1'b1;
            done_q   <= 1'b1;
            st_q     <= H_IDLE;
          end else if (tmr_up) begin
            sda_oe_q <= 1'b1; // RULE19
            tmr_q    <= HD_STA_CYC;
          end
        end
        H_BIT_S: begin
          sda_oe_q <= ~tx_q[8];
          tmr_q    <= LOW_CYC;
          st_q     <= H_BIT_L;
        end
        H_BIT_L: begin
          if (tmr_up) begin
            scl_oe_q <= 1'b0;
            tmr_q    <= HIGH_CYC;
            st_q     <= H_BIT_H;
          end
        end
        H_BIT_H: begin
          if (tmr_up) begin
            scl_oe_q <= 1'b1;
            rx_q     <= {rx_q[6:0], bus.sda};
            tx_q     <= {tx_q[7:0], 1'b1};
            if (cnt_q == BYTE_BITS) begin
              rd_q    <= rx_q;
              ack_q   <= ~bus.sda; // RULE1
              ready_q <= 1'b1;
              done_q  <= 1'b1;
              st_q    <= H_IDLE;
            end else begin
              cnt_q <= cnt_q + 4'h1;
              st_q  <= H_BIT_S;
            end
          end
        end
        H_STO_A: begin
          scl_oe_q <= 1'b1;
          sda_oe_q <= 1'b1;
          tmr_q    <= LOW_CYC;
          st_q     <= H_STO_B;
        end
        H_STO_B: begin
          if (tmr_up) begin
            scl_oe_q <= 1'b0;
            tmr_q    <= SU_STO_CYC;
            st_q     <= H_STO_C;
          end
        end
        H_STO_C: begin
          if (tmr_up && !sda_oe_q) begin
            ready_q <= 1'b1;
            done_q  <= 1'b1;
            st_q    <= H_IDLE;
          end else if (tmr_up) begin
            sda_oe_q <= 1'b0; // RULE19
            tmr_q    <= BUF_CYC;
          end
        end
      endcase
    end
  end

  // Open drain: both lines are only ever pulled low.
  assign bus.scl_m_out = 1'b0;
  assign bus.sda_m_out = 1'b0;
  assign bus.scl_m_oe  = scl_oe_q;
  assign bus.sda_m_oe  = sda_oe_q;
  assign cmd_ready_out = ready_q;
  assign done_out      = done_q;
  assign rd_data_out   = rd_q;
  assign ack_seen_out  = ack_q;

endmodule
`default_nettype wire

// [verification/srs_bus_props.sv]
// Checker for the slave side of the two-wire bus.
`timescale 1ns/100ps
`default_nettype none
module srs_bus_props
  import srs_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Bus lines.
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_oe
);
  logic       scl_p_q;
  logic       sda_p_q;
  logic [3:0] cnt_q;
  logic [7:0] shr_q;
  logic       first_q;
  logic       rd_q;
  logic       ok_q;
  logic       ackph_q;
  logic       nack_q;
  logic       act_q;
  logic       rise;
  logic       fall;
  logic       sta;
  logic       sto;
  logic       ninth;

  assign rise  = scl & ~scl_p_q;
  assign fall  = ~scl & scl_p_q;
  assign sta   = scl & scl_p_q & ~sda & sda_p_q;
  assign sto   = scl & scl_p_q & sda & ~sda_p_q;
  assign ninth = rise & (cnt_q == 4'h8);

  always_ff @(posedge ref_clk_in) begin
    scl_p_q <= scl | ~rst_b_in;
    sda_p_q <= sda | ~rst_b_in;
    if (rise) begin
      shr_q <= {shr_q[6:0], sda};
    end
  end

  // Bit position within the nine-bit unit; the ninth rise is the acknowledge.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in || sta || sto) begin
      cnt_q <= 4'h0;
    end else if (rise) begin
      cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in || fall) begin
      ackph_q <= 1'b0;
    end else if (ninth) begin
      ackph_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in || sto || sta) begin
      act_q   <= sta & rst_b_in;
      first_q <= sta & rst_b_in;
      rd_q    <= 1'b0;
      ok_q    <= 1'b0;
      nack_q  <= 1'b0;
    end else if (ninth) begin
      first_q <= 1'b0;
      if (first_q) begin
        rd_q <= shr_q[0];
        ok_q <= (shr_q[7:1] == SLAVE_ADDR[7:1]);
      end
      if (!first_q && rd_q && sda) begin
        nack_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_ack_rise;
    ninth && act_q;
  endsequence
  sequence s_acked;
    sda_s_oe && !sda;
  endsequence

  property p_ack_recv;
    s_ack_rise ##0 (first_q ? (shr_q[7:1] == SLAVE_ADDR[7:1]) : (ok_q && !rd_q)) |-> s_acked;
  endproperty
  a_ack_recv: assert property (p_ack_recv) else $error("slave did not acknowledge");
  property p_ack_release;
    ackph_q && fall && !rd_q |-> ##[1:2] !sda_s_oe;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack held too long");
  property p_ack_win;
    rise && act_q && (cnt_q != 4'h8) && !rd_q |-> !sda_s_oe;
  endproperty
  a_ack_win: assert property (p_ack_win) else $error("slave drove a data bit");
  property p_master_ack;
    s_ack_rise ##0 (rd_q && !first_q) |-> !sda_s_oe;
  endproperty
  a_master_ack: assert property (p_master_ack) else $error("slave drove master ack");
  property p_nack_release;
    nack_q |-> !sda_s_oe;
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("line held after nack");
  property p_idle_quiet;
    !act_q |-> !sda_s_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("slave drove idle bus");
  property p_hold_high;
    scl && scl_p_q |-> $stable(sda_s_oe);
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("drive changed, clock high");
  property p_change_low;
    $changed(sda_s_oe) |-> !scl && !$past(scl);
  endproperty
  a_change_low: assert property (p_change_low) else $error("drive changed off low phase");
endmodule
`default_nettype wire

// [verification/serial_ram_slave_port_tb.sv]
// Bench joining master and slave on one two-wire bus.
`timescale 1ns/100ps
`default_nettype none
module serial_ram_slave_port_tb
  import srs_pkg::*;
;
  logic             clk       = 1'b0;
  logic             rst_b     = 1'b0;
  logic             supply_ok = 1'b1;
  logic             cmd_valid = 1'b0;
  srs_op_t          cmd_op    = OP_START;
  logic [7:0]       cmd_data  = 8'h00;
  logic             cmd_ack   = 1'b0;
  logic [PTR_W-1:0] ptr;
  logic             wr_strobe;
  logic [7:0]       wr_data;
  logic             busy;
  logic             cmd_ready;
  logic             done;
  logic [7:0]       rd_data;
  logic             ack_seen;
  int               fails     = 0;
  int               n_tests   = 0;
  int               n_strobe  = 0;

  always #2.5 clk = ~clk;
  always @(negedge clk) if (wr_strobe === 1'b1) n_strobe++;

  srs_bus_if srs_bus_if_inst ();
  srs_slave srs_slave_inst (
    .ref_clk_in    (clk),
    .rst_b_in      (rst_b),
    .bus           (srs_bus_if_inst.dev),
    .supply_ok_in  (supply_ok),
    .ptr_out       (ptr),
    .wr_strobe_out (wr_strobe),
    .wr_data_out   (wr_data),
    .busy_out      (busy)
  );
  srs_master srs_master_inst (
    .ref_clk_in    (clk),
    .rst_b_in      (rst_b),
    .bus           (srs_bus_if_inst.host),
    .cmd_valid_in  (cmd_valid),
    .cmd_op_in     (cmd_op),
    .cmd_data_in   (cmd_data),
    .cmd_ack_in    (cmd_ack),
    .cmd_ready_out (cmd_ready),
    .done_out      (done),
    .rd_data_out   (rd_data),
    .ack_seen_out  (ack_seen)
  );
  srs_bus_props srs_bus_props_inst (
    .ref_clk_in (clk),
    .rst_b_in   (rst_b),
    .scl        (srs_bus_if_inst.scl),
    .sda        (srs_bus_if_inst.sda),
    .sda_s_oe   (srs_bus_if_inst.sda_s_oe)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("compares=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One command, held for one clock, then a bounded wait for its done pulse.
  task automatic cmd(input srs_op_t op, input logic [7:0] d, input logic a);
    int k;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_data  <= d;
    cmd_ack   <= a;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    for (k = 0; k < 20000 && done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 20000) begin
      fails++;
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] d);
    cmd(OP_WRITE, d, 1'b0);
    chk({7'h00, ack_seen}, 8'h01);
  endtask

  // The pointer moves on the clock fall that ends the acknowledge.
  task automatic ptr_is(input logic [PTR_W-1:0] exp);
    repeat (4) @(posedge clk);
    #1;
    chk({2'b00, ptr}, {2'b00, exp});
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    cmd(OP_START, 8'h00, 1'b0);
    wr(SLAVE_ADDR);
    wr(8'h3F);
    ptr_is(6'h3F);
    wr(8'hA5);
    chk(wr_data, 8'hA5);
    ptr_is(6'h00);
    wr(8'h3C);
    ptr_is(6'h01);
    chk(8'(n_strobe), 8'h02);
    cmd(OP_STOP, 8'h00, 1'b0);
    chk({6'h00, srs_bus_if_inst.scl, srs_bus_if_inst.sda}, 8'h03);
    $display("test write done");
    // The supply fails while the slave is addressing, so the abort has work to undo.
    cmd(OP_START, 8'h00, 1'b0);
    chk({7'h00, busy}, 8'h01);
    @(posedge clk);
    supply_ok <= 1'b0;
    ptr_is(6'h00);
    chk({7'h00, busy}, 8'h00);
    @(posedge clk);
    supply_ok <= 1'b1;
    $display("test supply done");
    cmd(OP_START, 8'h00, 1'b0);
    wr(SLAVE_ADDR | 8'h01);
    cmd(OP_READ, 8'h00, 1'b0);
    chk(rd_data, 8'h3C);
    chk({7'h00, ack_seen}, 8'h00);
    ptr_is(6'h00);
    chk({7'h00, srs_bus_if_inst.sda_s_oe}, 8'h00);
    cmd(OP_STOP, 8'h00, 1'b0);
    $display("test read done");
    close_out();
  end
endmodule
`default_nettype wire
